/* src/mpr_device.sv */
// Memory end: mode registers, multipurpose register pages and readout.
// Assumes the controller keeps its own command-ordering obligations.
`default_nettype none
// Overview of operation
// RULE1: Four pages of four 8-bit registers.
// RULE2: Bit A2 of control register enables mode.
// RULE3: Field A1:0 of control register selects page.
// RULE4: Controller precharges all banks before the MRS.
// RULE5: Reads go to selected register while enabled.
// RULE6: Controller issues only allowed command types.
// RULE7: Autoprecharge variants behave as plain read/write.
// RULE8: No power-down or self refresh while enabled.
// RULE9: Controller uses no bus inversion on reads.
// RULE10: Controller waits tRFC after each refresh.
// RULE11: Only 1x refresh; sequences finish first.
// RULE12: Reads use BL8 or BC4, never on-the-fly.
// RULE13: Page 0 defaults 55, 33, 0F, 00.
// RULE14: Writes change page 0 only, kept till reset.
// RULE15: Pages: training, parity frame, mode regs, reserved.
// RULE16: Page 0 serial or parallel; others serial.
// RULE17: Bit 7 is A7 and first UI.
// RULE18: Bank address bits pick register within page.
// RULE19: Serial: same sequence on every lane.
// RULE20: Parallel: lane pattern repeated every UI.
// RULE21: Parallel readout reads location 0 only.
// RULE22: Mode registers read as lower/upper halves.
// RULE23: Clearing enable returns reads to the array.
module mpr_device (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    ddr_link_if.device lnk,
    input wire logic [4*ddr_mpr_pkg::REG_W-1:0] i_parity_frame,
    input wire logic [ddr_mpr_pkg::LANES-1:0] i_array_data,
    input wire logic i_violation_clr,
    output logic o_array_rd,
    output logic o_array_wr,
    output logic [1:0] o_array_bank,
    output logic [ddr_mpr_pkg::ADDR_W-1:0] o_array_col,
    output logic [ddr_mpr_pkg::LANES-1:0] o_array_wdata,
    output logic o_mpr_active,
    output logic [1:0] o_page,
    output logic o_violation
);
    import ddr_mpr_pkg::*;

    localparam int SYNC_W = 1 + 4 + 2 + ADDR_W + LANES;

    // =========================================================
    // Pin synchronisation and link edge detection
    logic [SYNC_W-1:0] sync_bus;
    logic s_lclk;
    logic [3:0] s_cmd_raw;
    logic [1:0] s_ba;
    logic [ADDR_W-1:0] s_addr;
    logic [LANES-1:0] s_dq;
    logic lclk_prev_q;
    logic rise;
    cmd_t cmd;

    link_sync #(
        .W(SYNC_W)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_async({lnk.link_clk, lnk.cmd, lnk.ba, lnk.addr, lnk.dq}),
        .o_sync(sync_bus)
    );
    assign {s_lclk, s_cmd_raw, s_ba, s_addr, s_dq} = sync_bus;
    assign cmd = cmd_t'(s_cmd_raw);

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            lclk_prev_q <= 1'b0;
        else if (i_ce)
            lclk_prev_q <= s_lclk;
    end
    assign rise = i_ce && s_lclk && !lclk_prev_q;

    // =========================================================
    // Command decode
    logic is_rd;
    logic is_wr;
    logic is_mrs;
    logic mpr_on;
    logic [1:0] page;
    logic [1:0] fmt;
    logic [ADDR_W-1:0] mode_reg_q [REGS_PER_PAGE];

    // Autoprecharge variants decode the same as the plain commands
    assign is_rd = rise && (cmd == CMD_RD || cmd == CMD_RDA); // [RULE7]
    assign is_wr = rise && (cmd == CMD_WR || cmd == CMD_WRA); // [RULE7]
    assign is_mrs = rise && cmd == CMD_MRS;
    assign mpr_on = mode_reg_q[MR_CTRL3][MPR_EN_BIT]; // [RULE2]
    assign page = mode_reg_q[MR_CTRL3][PAGE_LSB +: 2]; // [RULE3]
    assign fmt = mode_reg_q[MR_CTRL3][FMT_LSB +: 2];

    // =========================================================
    // Mode registers
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            for (int i = 0; i < REGS_PER_PAGE; i++)
                mode_reg_q[i] <= '0;
        end
        else if (is_mrs)
        begin
            // Enable, disable and page change all arrive here
            mode_reg_q[s_ba] <= s_addr; // [RULE2] [RULE3] [RULE23]
        end
    end

    // =========================================================
    // Page 0 training patterns
    logic [REG_W-1:0] pat_q [REGS_PER_PAGE];
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pat_q[0] <= PAT0_RST; // [RULE13]
            pat_q[1] <= PAT1_RST; // [RULE13]
            pat_q[2] <= PAT2_RST; // [RULE13]
            pat_q[3] <= PAT3_RST; // [RULE13]
        end
        else if (is_wr && mpr_on && page == PAGE_TRAIN)
        begin
            // Data comes from A7..A0, bit 7 from A7
            pat_q[s_ba] <= s_addr[REG_W-1:0]; // [RULE14] [RULE17] [RULE18]
        end
    end

    // =========================================================
    // Register selection
    logic [REG_W-1:0] rd_value;
    logic [2*REG_W-1:0] mr_wide;
    always_comb
    begin
        mr_wide = {{(2*REG_W-ADDR_W){1'b0}}, mode_reg_q[s_addr[1:0]]};
        case (page) // [RULE1] [RULE15]
            PAGE_TRAIN: rd_value = pat_q[s_ba]; // [RULE18]
            PAGE_PARITY: rd_value = i_parity_frame[s_ba*REG_W +: REG_W];
            // Bank bit 0 picks the lower or upper half
            PAGE_MODE: rd_value = mr_wide[s_ba[0]*REG_W +: REG_W]; // [RULE22]
            default: rd_value = '0;
        endcase
    end

    // =========================================================
    // Readout formatting
    function automatic logic [LANES-1:0] ui_byte(
        input logic [REG_W-1:0] v,
        input logic mpr,
        input logic par,
        input int ui
    );
        logic [LANES-1:0] b;
        b = v;
        if (mpr && par)
        begin
            // Lane 0 carries bit 7, same pattern in every UI
            for (int j = 0; j < LANES; j++)
                b[j] = v[REG_W-1-j]; // [RULE20]
        end
        else if (mpr)
        begin
            // UI0 carries bit 7 on every lane
            b = {LANES{v[REG_W-1-ui]}}; // [RULE17] [RULE19]
        end
        return b;
    endfunction

    logic par_sel;
    logic [REG_W-1:0] src_byte;
    logic [LANES-1:0] burst_d [BURST_UIS];

    // Only page 0 may leave serial format
    assign par_sel = page == PAGE_TRAIN && fmt == FMT_PARALLEL; // [RULE16]
    assign src_byte = mpr_on ? rd_value : i_array_data; // [RULE5] [RULE23]

    genvar gu;
    generate
        for (gu = 0; gu < BURST_UIS; gu++)
        begin : g_ui
            assign burst_d[gu] = ui_byte(src_byte, mpr_on, par_sel, gu);
        end
    endgenerate

    // =========================================================
    // Burst output on the data lanes
    logic [LANES-1:0] burst_q [BURST_UIS];
    logic [LANES-1:0] dq_q;
    logic oe_n_q;
    logic [3:0] ui_q;
    logic [3:0] len_q;

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            for (int i = 0; i < BURST_UIS; i++)
                burst_q[i] <= '0;
            dq_q <= '0;
            oe_n_q <= 1'b1;
            ui_q <= '0;
            len_q <= '0;
        end
        else if (is_rd)
        begin
            burst_q <= burst_d;
            dq_q <= burst_d[0];
            oe_n_q <= 1'b0;
            ui_q <= 4'h1;
            len_q <= s_addr[CHOP_N_BIT] ? BL8_LEN : BC4_LEN;
        end
        else if (rise && !oe_n_q)
        begin
            if (ui_q == len_q)
                oe_n_q <= 1'b1;
            else
            begin
                dq_q <= burst_q[ui_q[2:0]];
                ui_q <= ui_q + 4'h1;
            end
        end
    end
    assign lnk.dev_dq_o = dq_q;
    assign lnk.dev_dq_oe_n = oe_n_q;

    // =========================================================
    // Array requests when the mode is off
    logic array_rd_q;
    logic array_wr_q;
    logic [1:0] array_bank_q;
    logic [ADDR_W-1:0] array_col_q;
    logic [LANES-1:0] array_wdata_q;

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            array_rd_q <= 1'b0;
            array_wr_q <= 1'b0;
            array_bank_q <= '0;
            array_col_q <= '0;
            array_wdata_q <= '0;
        end
        else if (i_ce)
        begin
            array_rd_q <= is_rd && !mpr_on; // [RULE23]
            array_wr_q <= is_wr && !mpr_on;
            if ((is_rd || is_wr) && !mpr_on)
            begin
                array_bank_q <= s_ba;
                array_col_q <= s_addr;
                array_wdata_q <= s_dq;
            end
        end
    end

    // =========================================================
    // Sticky flag for commands the controller must not send
    logic bad_cmd;
    logic violation_q;
    assign bad_cmd = rise && mpr_on && (cmd == CMD_ACT || cmd == CMD_PRE // [RULE6]
        || cmd == CMD_PDE || cmd == CMD_SRE // [RULE8]
        || (cmd == CMD_REF && !oe_n_q) // [RULE11]
        || (is_rd && mode_reg_q[MR_BURST][1:0] == BL_OTF)); // [RULE12]

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
            violation_q <= 1'b0;
        else if (bad_cmd)
            violation_q <= 1'b1;
        else if (i_ce && i_violation_clr)
            violation_q <= 1'b0;
    end

    assign o_array_rd = array_rd_q;
    assign o_array_wr = array_wr_q;
    assign o_array_bank = array_bank_q;
    assign o_array_col = array_col_q;
    assign o_array_wdata = array_wdata_q;
    assign o_mpr_active = mode_reg_q[MR_CTRL3][MPR_EN_BIT];
    assign o_page = mode_reg_q[MR_CTRL3][PAGE_LSB +: 2];
    assign o_violation = violation_q;
endmodule
`default_nettype wire

/* src/ddr_mpr_pkg.sv */
// Constants, command codes and timing shared by both ends of the link.
// Assumes a 100 MHz system clock on both ends.
`default_nettype none
package ddr_mpr_pkg;
    // =========================================================
    // Geometry
    localparam int REG_W = 8;
    localparam int LANES = 8;
    localparam int REGS_PER_PAGE = 4;
    localparam int PAGE_COUNT = 4;
    localparam int ADDR_W = 13;
    localparam int BURST_UIS = 8;
    localparam logic [3:0] BL8_LEN = 4'h8;
    localparam logic [3:0] BC4_LEN = 4'h4;
    // =========================================================
    // Mode register numbers and field positions
    localparam logic [1:0] MR_BURST = 2'h0;
    localparam logic [1:0] MR_CTRL3 = 2'h3;
    localparam int MPR_EN_BIT = 2;
    localparam int PAGE_LSB = 0;
    localparam int FMT_LSB = 11;
    localparam int RATE_LSB = 6;
    localparam int CHOP_N_BIT = 12;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] FMT_SERIAL = 2'h0;
    localparam logic [1:0] FMT_PARALLEL = 2'h1;
    localparam logic [1:0] PAGE_TRAIN = 2'h0;
    localparam logic [1:0] PAGE_PARITY = 2'h1;
    localparam logic [1:0] PAGE_MODE = 2'h2;
    // =========================================================
    // Values after reset
    localparam logic [7:0] PAT0_RST = 8'h55;
    localparam logic [7:0] PAT1_RST = 8'h33;
    localparam logic [7:0] PAT2_RST = 8'h0F;
    localparam logic [7:0] PAT3_RST = 8'h00;
    // =========================================================
    // Timing
    localparam int SYS_PERIOD_NS = 10;
    localparam int TRFC_NS = 260;
    localparam int TRP_NS = 15;
    localparam int TRFC_CYC = (TRFC_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int TRP_CYC = (TRP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int LINK_HALF_CYC = 4;
    // =========================================================
    // Link commands
    typedef enum logic [3:0] {
        CMD_DES, CMD_MRS, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA,
        CMD_REF, CMD_ACT, CMD_PRE, CMD_PDE, CMD_SRE
    } cmd_t;
endpackage
`default_nettype wire

/* src/ddr_link_if.sv */
// Command/address and data link between controller and memory.
// Resolves the shared data wire from the two enables (low = driving).
`default_nettype none
interface ddr_link_if;
    import ddr_mpr_pkg::*;
    logic link_clk;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] host_dq_o;
    logic host_dq_oe_n;
    logic [LANES-1:0] dev_dq_o;
    logic dev_dq_oe_n;
    logic [LANES-1:0] dq;
    assign dq = !dev_dq_oe_n ? dev_dq_o : (!host_dq_oe_n ? host_dq_o : '0);
    modport host (output link_clk, output cmd, output ba, output addr,
        output host_dq_o, output host_dq_oe_n, input dq);
    modport device (input link_clk, input cmd, input ba, input addr,
        input dq, output dev_dq_o, output dev_dq_oe_n);
endinterface
`default_nettype wire

/* src/link_sync.sv */
// Two-stage synchroniser for a bundle of link pins.
// Assumes each bit is stable for several system clocks around its use.
`default_nettype none
module link_sync #(
    parameter int W = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (i_ce)
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end
    assign o_sync = sync_q;
endmodule
`default_nettype wire

/* src/mpr_host.sv */
// Controller end: makes the link clock, sends one command per request,
// refuses illegal commands and collects read bursts.
// Assumes LINK_HALF of at least 4 so read data settles before capture.
`default_nettype none
module mpr_host #(
    parameter int LINK_HALF = ddr_mpr_pkg::LINK_HALF_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    ddr_link_if.host lnk,
    input wire logic i_req_valid,
    input wire ddr_mpr_pkg::cmd_t i_req_op,
    input wire logic [1:0] i_req_ba,
    input wire logic [ddr_mpr_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [ddr_mpr_pkg::LANES-1:0] i_req_wdata,
    output logic o_req_ready,
    output logic o_req_refused,
    output logic o_rsp_valid,
    output logic [ddr_mpr_pkg::BURST_UIS*ddr_mpr_pkg::LANES-1:0] o_rsp_data
);
    import ddr_mpr_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_ARM, H_HOLD, H_READ} hstate_t;

    // =========================================================
    // Link clock divider
    logic [7:0] half_q;
    logic lclk_q;
    logic tick;
    logic rise_ev;
    logic fall_ev;
    assign tick = i_ce && half_q == 8'(LINK_HALF - 1);
    assign rise_ev = tick && !lclk_q;
    assign fall_ev = tick && lclk_q;
    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            half_q <= '0;
            lclk_q <= 1'b0;
        end
        else if (i_ce)
        begin
            half_q <= tick ? 8'h00 : half_q + 8'h01;
            if (tick)
                lclk_q <= !lclk_q;
        end
    end

    logic [LANES-1:0] s_dq;
    link_sync #(
        .W(LANES)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_async(lnk.dq),
        .o_sync(s_dq)
    );

    // =========================================================
    // Device model and legality
    hstate_t state_q;
    logic mpr_q;
    logic par_q;
    logic otf_q;
    logic [3:0] open_q;
    logic [8:0] wait_q;
    logic ready_q;
    logic take;
    logic refuse;
    logic is_rd_req;
    assign take = i_ce && ready_q && i_req_valid;
    assign is_rd_req = i_req_op == CMD_RD || i_req_op == CMD_RDA;
    assign refuse = (mpr_q && (i_req_op == CMD_ACT || i_req_op == CMD_PRE // [RULE6]
            || i_req_op == CMD_PDE || i_req_op == CMD_SRE)) // [RULE8]
        || (i_req_op == CMD_MRS && open_q != 4'h0) // [RULE4]
        || (mpr_q && is_rd_req && (otf_q || (par_q && i_req_ba != 2'h0))) // [RULE12] [RULE21]
        || (i_req_op == CMD_MRS && i_req_ba == MR_CTRL3 && i_req_addr[MPR_EN_BIT]
            && i_req_addr[RATE_LSB +: 3] != 3'h0) // [RULE11]
        || (mpr_q && i_req_op == CMD_MRS && i_req_ba == MR_BURST
            && i_req_addr[1:0] == BL_OTF); // [RULE12]

    // =========================================================
    // Request sequencing
    cmd_t op_q;
    logic [1:0] ba_q;
    logic [ADDR_W-1:0] addr_q;
    logic [LANES-1:0] wdata_q;
    logic [3:0] cmd_q;
    logic [3:0] ui_q;
    logic refused_q;
    logic rsp_valid_q;
    logic [BURST_UIS*LANES-1:0] rsp_q;
    logic dq_oe_n_q;

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_q <= H_IDLE;
            op_q <= CMD_DES;
            ba_q <= '0;
            addr_q <= '0;
            wdata_q <= '0;
            cmd_q <= 4'(CMD_DES);
            dq_oe_n_q <= 1'b1;
            ui_q <= '0;
            refused_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
            ready_q <= 1'b0;
            mpr_q <= 1'b0;
            par_q <= 1'b0;
            otf_q <= 1'b0;
            open_q <= '0;
            wait_q <= '0;
        end
        else if (i_ce)
        begin
            refused_q <= take && refuse;
            rsp_valid_q <= 1'b0;
            ready_q <= state_q == H_IDLE && wait_q <= 9'h001 && !take;
            if (wait_q != 9'h000)
                wait_q <= wait_q - 9'h001;
            if (fall_ev)
            begin
                cmd_q <= 4'(CMD_DES);
                dq_oe_n_q <= 1'b1;
            end
            case (state_q)
                H_IDLE:
                begin
                    if (take && !refuse)
                    begin
                        op_q <= i_req_op;
                        ba_q <= i_req_ba;
                        addr_q <= i_req_addr;
                        wdata_q <= i_req_wdata;
                        state_q <= H_ARM;
                    end
                end
                H_ARM:
                begin
                    if (fall_ev)
                    begin
                        cmd_q <= 4'(op_q);
                        // Only array writes use the data lanes; no inversion
                        dq_oe_n_q <= !((op_q == CMD_WR || op_q == CMD_WRA)
                            && !mpr_q); // [RULE9]
                        state_q <= H_HOLD;
                    end
                end
                H_HOLD:
                begin
                    if (rise_ev)
                    begin
                        ui_q <= '0;
                        state_q <= (op_q == CMD_RD || op_q == CMD_RDA) ? H_READ : H_IDLE;
                        rsp_valid_q <= !(op_q == CMD_RD || op_q == CMD_RDA);
                        if (op_q == CMD_MRS && ba_q == MR_CTRL3)
                        begin
                            mpr_q <= addr_q[MPR_EN_BIT];
                            par_q <= addr_q[PAGE_LSB +: 2] == PAGE_TRAIN
                                && addr_q[FMT_LSB +: 2] == FMT_PARALLEL;
                        end
                        if (op_q == CMD_MRS && ba_q == MR_BURST)
                            otf_q <= addr_q[1:0] == BL_OTF;
                        if (op_q == CMD_ACT)
                            open_q[ba_q] <= 1'b1;
                        if (op_q == CMD_PRE)
                        begin
                            open_q[ba_q] <= 1'b0;
                            wait_q <= 9'(TRP_CYC); // [RULE4]
                        end
                        if (op_q == CMD_REF)
                            wait_q <= 9'(TRFC_CYC); // [RULE10]
                    end
                end
                H_READ:
                begin
                    if (rise_ev)
                    begin
                        rsp_q[ui_q[2:0]*LANES +: LANES] <= s_dq;
                        ui_q <= ui_q + 4'h1;
                        // Refresh can only be taken after the burst ends
                        if (ui_q + 4'h1 == (addr_q[CHOP_N_BIT] ? BL8_LEN : BC4_LEN))
                        begin
                            rsp_valid_q <= 1'b1; // [RULE11]
                            state_q <= H_IDLE;
                        end
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    assign lnk.link_clk = lclk_q;
    assign lnk.cmd = cmd_q;
    assign lnk.ba = ba_q;
    assign lnk.addr = addr_q;
    assign lnk.host_dq_o = wdata_q;
    assign lnk.host_dq_oe_n = dq_oe_n_q;
    assign o_req_ready = ready_q;
    assign o_req_refused = refused_q;
    assign o_rsp_valid = rsp_valid_q;
    assign o_rsp_data = rsp_q;
endmodule
`default_nettype wire

/* bench/mpr_link_properties.sv */
// Wire-level checks on the link between the controller and memory ends.
// Assumes every link signal is sampled on the shared system clock.
`default_nettype none
module mpr_link_properties (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic link_clk,
    input wire logic [3:0] cmd,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic host_dq_oe_n,
    input wire logic [7:0] dev_dq_o,
    input wire logic dev_dq_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import ddr_mpr_pkg::*;
    // ====================
    // Mode, format and refresh spacing as seen at link rising edges
    logic lclk_q, mode_q, par_q, rd_q, rise, pmode;
    logic [1:0] page_q;
    logic [5:0] gap_q;
    assign rise = link_clk && !lclk_q;
    assign pmode = mode_q && par_q && page_q == 2'h0;
    always_ff @(posedge i_sys_clk or posedge i_reset)
        if (i_reset)
        begin
            lclk_q <= 1'b0;
            mode_q <= 1'b0;
            par_q <= 1'b0;
            rd_q <= 1'b0;
            page_q <= 2'h0;
        end
        else
        begin
            lclk_q <= link_clk;
            if (rise)
                rd_q <= cmd == CMD_RD || cmd == CMD_RDA;
            if (rise && cmd == CMD_MRS && ba == MR_CTRL3)
            begin
                mode_q <= addr[MPR_EN_BIT];
                page_q <= addr[1:0];
                par_q <= addr[12:11] == FMT_PARALLEL;
            end
        end
    always_ff @(posedge i_sys_clk or posedge i_reset)
        if (i_reset)
            gap_q <= 6'h3F;
        else if (rise && cmd == CMD_REF)
            gap_q <= 6'h00;
        else if (gap_q != 6'h3F)
            gap_q <= gap_q + 6'h01;
    // ====================
    // Assertions
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    sequence two_ui_s;
        !dev_dq_oe_n ##1 !dev_dq_oe_n;
    endsequence
    allowed_cmd_a: assert property (
        rise && mode_q |-> cmd inside {CMD_DES, CMD_MRS, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA,
        CMD_REF}) else $error("forbidden command in mode");
    ref_gap_a: assert property (
        rise && cmd != CMD_DES |-> gap_q >= TRFC_CYC) else $error("command inside tRFC");
    ref_idle_a: assert property (
        rise && cmd == CMD_REF |-> dev_dq_oe_n) else $error("refresh during burst");
    read_out_a: assert property (
        $fell(dev_dq_oe_n) |-> rd_q) else $error("data driven without read");
    host_drive_a: assert property (
        !host_dq_oe_n |-> !mode_q) else $error("host drives data in mode");
    serial_lanes_a: assert property (
        !dev_dq_oe_n && mode_q && !pmode |-> dev_dq_o inside {8'h00, 8'hFF})
        else $error("serial lanes differ");
    parallel_hold_a: assert property (
        pmode ##0 two_ui_s |-> $stable(dev_dq_o)) else $error("parallel pattern moved");
    page_three_a: assert property (
        !dev_dq_oe_n && mode_q && page_q == 2'h3 |-> dev_dq_o == 8'h00)
        else $error("reserved page not zero");
endmodule
`default_nettype wire

/* bench/dram_multipurpose_register_access_tb.sv */
// Self-checking bench: controller and memory ends joined over the link.
// Assumes a 100 MHz clock and the host's default link divider.
`default_nettype none
module dram_multipurpose_register_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ddr_mpr_pkg::*;
    // ====================
    // Stimulus and instances
    logic clk = 1'b0, rst = 1'b1, vld = 1'b0, rdy, refd, rv, act;
    cmd_t op = CMD_DES;
    cmd_t bad[4] = '{CMD_ACT, CMD_PRE, CMD_PDE, CMD_SRE};
    logic [1:0] ba = 2'h0, pg;
    logic [12:0] ad = 13'h0000;
    logic [31:0] pfr = 32'h12345678;
    logic [63:0] rd;
    int mismatches = 0, total_checks = 0;
    ddr_link_if lnk();
    always #5 clk = ~clk;
    mpr_host i_mpr_host (.i_sys_clk(clk), .i_reset(rst), .i_ce(1'b1), .lnk(lnk),
        .i_req_valid(vld), .i_req_op(op), .i_req_ba(ba), .i_req_addr(ad),
        .i_req_wdata(8'h5A), .o_req_ready(rdy), .o_req_refused(refd),
        .o_rsp_valid(rv), .o_rsp_data(rd));
    mpr_device i_mpr_device (.i_sys_clk(clk), .i_reset(rst), .i_ce(1'b1), .lnk(lnk),
        .i_parity_frame(pfr), .i_array_data(8'h3C), .i_violation_clr(1'b0),
        .o_array_rd(), .o_array_wr(), .o_array_bank(), .o_array_col(),
        .o_array_wdata(), .o_mpr_active(act), .o_page(pg), .o_violation());
    mpr_link_properties i_mpr_link_properties (.i_sys_clk(clk), .i_reset(rst),
        .link_clk(lnk.link_clk), .cmd(lnk.cmd), .ba(lnk.ba), .addr(lnk.addr),
        .host_dq_oe_n(lnk.host_dq_oe_n), .dev_dq_o(lnk.dev_dq_o),
        .dev_dq_oe_n(lnk.dev_dq_oe_n));
    // ====================
    // Shared tasks
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [63:0] ser(input logic [7:0] v);
        for (int k = 0; k < 8; k++)
            ser[8*k +: 8] = {8{v[7-k]}};
    endfunction
    // Expect refusal x; both flags compared so a hang also fails
    task automatic req(input cmd_t o, input logic [1:0] b, input logic [12:0] a, input logic x);
        op = o;
        ba = b;
        ad = a;
        vld = 1'b1;
        while (rdy !== 1'b1)
        begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 vld = 1'b0;
        repeat (400)
        begin
            if (rv === 1'b1 || refd === 1'b1)
                break;
            @(posedge clk);
            #1;
        end
        chk({refd, rv}, {x, !x});
        @(posedge clk) #1;
    endtask
    task automatic rdchk(input cmd_t o, input logic [1:0] b, input logic [12:0] a,
        input logic [63:0] e);
        req(o, b, a, 1'b0);
        chk(rd, e);
    endtask
    // ====================
    // Scenarios
    task automatic t_defaults();
        req(CMD_MRS, 2'h3, 13'h0004, 1'b0);
        rdchk(CMD_RD, 2'h0, 13'h1000, ser(8'h55));
        chk({act, pg}, 3'h4);
        rdchk(CMD_RD, 2'h1, 13'h1000, ser(8'h33));
        rdchk(CMD_RDA, 2'h2, 13'h1000, ser(8'h0F));
        rdchk(CMD_RD, 2'h3, 13'h1000, ser(8'h00));
        req(CMD_MRS, 2'h0, 13'h0001, 1'b1);
    endtask
    task automatic t_write();
        req(CMD_WR, 2'h2, 13'h00A5, 1'b0);
        req(CMD_WRA, 2'h1, 13'h00C3, 1'b0);
        rdchk(CMD_RDA, 2'h2, 13'h1000, ser(8'hA5));
        rdchk(CMD_RD, 2'h1, 13'h1000, ser(8'hC3));
        req(CMD_MRS, 2'h3, 13'h0804, 1'b0);
        rdchk(CMD_RD, 2'h0, 13'h1000, {8{8'hAA}});
        req(CMD_RD, 2'h1, 13'h1000, 1'b1);
    endtask
    task automatic t_pages();
        req(CMD_MRS, 2'h3, 13'h0805, 1'b0);
        rdchk(CMD_RD, 2'h1, 13'h1000, ser(8'h56));
        req(CMD_MRS, 2'h3, 13'h1006, 1'b0);
        rdchk(CMD_RD, 2'h0, 13'h1003, ser(8'h06));
        rdchk(CMD_RD, 2'h1, 13'h1003, ser(8'h10));
        req(CMD_MRS, 2'h3, 13'h0007, 1'b0);
        rdchk(CMD_RD, 2'h2, 13'h1000, ser(8'h00));
        foreach (bad[i])
            req(bad[i], 2'h0, 13'h0000, 1'b1);
        req(CMD_REF, 2'h0, 13'h0000, 1'b0);
        rdchk(CMD_RD, 2'h0, 13'h1000, ser(8'h00));
    endtask
    task automatic t_exit();
        req(CMD_MRS, 2'h3, 13'h0000, 1'b0);
        rdchk(CMD_RD, 2'h0, 13'h1000, {8{8'h3C}});
        req(CMD_ACT, 2'h0, 13'h0000, 1'b0);
        req(CMD_MRS, 2'h3, 13'h0004, 1'b1);
        chk(act, 1'b0);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        t_defaults();
        t_write();
        t_pages();
        t_exit();
        tally_and_finish();
    end
    initial
    begin
        #400000;
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
